// *** hw/ipv_pkg.sv ***
// Package: register map, vector table and priorities of the interrupt block
package ipv_pkg;
    // Number of prioritised maskable sources (priority 1..16)
    localparam int unsigned IPV_NSRC = 16;
    // Register byte addresses (word aligned)
    localparam logic [7:0] IPV_ADDR_CTRL = 8'h00;
    localparam logic [7:0] IPV_ADDR_ENABLE = 8'h04;
    localparam logic [7:0] IPV_ADDR_FLAGS = 8'h08;
    localparam logic [7:0] IPV_ADDR_FLAG_CLR = 8'h0c;
    localparam logic [7:0] IPV_ADDR_STATUS = 8'h10;
    localparam logic [7:0] IPV_ADDR_VECTOR = 8'h14;
    localparam logic [7:0] IPV_ADDR_SRC_SET = 8'h18;
    // Control register fields
    localparam int unsigned IPV_CTRL_MASK_BIT = 0;
    localparam int unsigned IPV_CTRL_TRAP_BIT = 1;
    localparam int unsigned IPV_CTRL_BOUNDARY_BIT = 2;
    localparam int unsigned IPV_CTRL_ACK_BIT = 3;
    // Source index within the flag vector (bit i = priority i+1)
    localparam int unsigned IPV_SRC_EXT_PIN = 0;
    localparam int unsigned IPV_SRC_LOCK = 1;
    localparam int unsigned IPV_SRC_T1_CH0 = 2;
    localparam int unsigned IPV_SRC_T1_CH1 = 3;
    localparam int unsigned IPV_SRC_T1_WRAP = 4;
    localparam int unsigned IPV_SRC_T2_CH0 = 5;
    localparam int unsigned IPV_SRC_T2_CH1 = 6;
    localparam int unsigned IPV_SRC_T2_WRAP = 7;
    // Vector addresses: reset pair on top, each lower priority two bytes below
    localparam logic [15:0] IPV_VEC_RESET = 16'hfffe;
    localparam logic [15:0] IPV_VEC_TRAP = 16'hfffc;
    localparam logic [15:0] IPV_VEC_STEP = 16'h0002;
    localparam logic [4:0] IPV_PRIO_TRAP = 5'h00;
    localparam logic [4:0] IPV_PRIO_NONE = 5'h1f;
    // Reset value of the global mask: set, as after reset
    localparam logic IPV_MASK_RST = 1'b1;
    // Service state of the core handshake
    typedef enum logic [1:0] {IPV_IDLE, IPV_LATCHED} ipv_state_t;
endpackage

// *** hw/ipv_src_if.sv ***
// Interface carrying source flags and enables between the block's modules
`timescale 1ns/10ps
`default_nettype none
interface ipv_src_if;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] gated;
    modport collect (output flags, input enables);
    modport arbiter (input flags, input enables, output gated);
endinterface
`default_nettype wire

// *** hw/ipv_arbiter.sv ***
// Fixed-priority resolver: gates flags by enables, finds the winner
`timescale 1ns/10ps
`default_nettype none
module ipv_arbiter
    import ipv_pkg::*;
(
    // Flags and enables
    ipv_src_if.arbiter src,
    // Result
    output logic req_any,
    output logic [4:0] win_prio
);
    // Per-source local enables gate each flag
    assign src.gated = src.flags & src.enables;

    // Lowest index is highest priority; scan from the top down so it ends winning
    always_comb begin
        req_any = 1'b0;
        win_prio = IPV_PRIO_NONE;
        for (int i = IPV_NSRC - 1; i >= 0; i--) begin
            if (src.gated[i]) begin
                req_any = 1'b1;
                win_prio = 5'(i + 1);
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/ipv_collect.sv ***
// Source flag collection: edge detect, lock change, timer events
`timescale 1ns/10ps
`default_nettype none
module ipv_collect
    import ipv_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Raw events
    input wire logic ext_pin_n,
    input wire logic lock_in,
    input wire logic [7:0] event_in,
    input wire logic [7:0] other_req,
    // Software clear and test set of flags
    input wire logic [15:0] clr,
    input wire logic [15:0] set,
    // Flags out
    ipv_src_if.collect src
);
    logic [2:0] pin_sync_reg, pin_sync_next;
    logic pin_state_reg, pin_state_next;
    logic [2:0] lock_sync_reg, lock_sync_next;
    logic lock_state_reg, lock_state_next;
    logic [7:0] flag_reg, flag_next;
    logic pin_fall, lock_change;

    // Pin change counts once the second and third stages agree
    always_comb begin
        pin_sync_next = {pin_sync_reg[1:0], ext_pin_n};
        pin_state_next = pin_state_reg;
        if (pin_sync_reg[2] == pin_sync_reg[1]) begin
            pin_state_next = pin_sync_reg[2];
        end
        // Lock indication is asynchronous too: same three-stage filter
        lock_sync_next = {lock_sync_reg[1:0], lock_in};
        lock_state_next = lock_state_reg;
        if (lock_sync_reg[2] == lock_sync_reg[1]) begin
            lock_state_next = lock_sync_reg[2];
        end
        pin_fall = pin_state_reg & ~pin_state_next;
        lock_change = lock_state_reg ^ lock_state_next;
        // Set wins over clear so an event in the clearing cycle survives
        flag_next = flag_reg & ~clr[7:0];
        flag_next[IPV_SRC_EXT_PIN] = flag_next[IPV_SRC_EXT_PIN] | pin_fall;
        flag_next[IPV_SRC_LOCK] = flag_next[IPV_SRC_LOCK] | lock_change;
        // Timer wrap and channel events are one-cycle pulses from the timers
        flag_next[7:2] = flag_next[7:2] | event_in[7:2];
        flag_next = flag_next | set[7:0];
    end

    // Idle pin and lock taken as high/low at reset; no spurious edge then
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync_reg <= 3'h7;
            pin_state_reg <= 1'b1;
            lock_sync_reg <= 3'h0;
            lock_state_reg <= 1'b0;
            flag_reg <= 8'h00;
        end else if (ce) begin
            pin_sync_reg <= pin_sync_next;
            pin_state_reg <= pin_state_next;
            lock_sync_reg <= lock_sync_next;
            lock_state_reg <= lock_state_next;
            flag_reg <= flag_next;
        end
    end

    // Upper sources are level requests owned by their peripherals
    assign src.flags = {other_req, flag_reg};

    // Edge flag stays set until cleared, regardless of pin level
    ext_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && flag_reg[IPV_SRC_EXT_PIN] && !clr[IPV_SRC_EXT_PIN]
        |=> flag_reg[IPV_SRC_EXT_PIN])
        else $error("external request flag lost");
    lock_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && lock_change |=> flag_reg[IPV_SRC_LOCK])
        else $error("lock change not flagged");
    timer_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && event_in[IPV_SRC_T1_WRAP] |=> flag_reg[IPV_SRC_T1_WRAP])
        else $error("first timer wrap not flagged");
    timer2_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && event_in[IPV_SRC_T2_WRAP] |=> flag_reg[IPV_SRC_T2_WRAP])
        else $error("second timer wrap not flagged");
    chan_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && (event_in[IPV_SRC_T1_CH0] || event_in[IPV_SRC_T2_CH1])
        |=> (flag_reg[IPV_SRC_T1_CH0] || flag_reg[IPV_SRC_T2_CH1]))
        else $error("channel event not flagged");
endmodule
`default_nettype wire

// *** hw/ipv_top.sv ***
// Interrupt priority and vector block with a Wishbone register slave
// -----------------------------------------------------------------
// Functional notes
// - The global mask blocks every maskable request but never the software trap.
// - Priorities run from 0 (reset and trap) down to 16 (timebase); lowest number wins.
// - A falling edge on the external pin latches a flag that holds until cleared.
// - Every change of the clock lock indication sets the lock-change flag.
// - The lock-change flag requests only while its enable is set.
// - First timer wrap sets its flag and requests only with its enable set.
// - Second timer wrap sets its flag and requests only with its enable set.
// - Capture or compare on a timer channel sets that channel's flag.
// - A first-timer channel flag requests only with its channel enable set.
// - A second-timer channel flag requests only with its channel enable set.
// - Requests are judged only at instruction boundaries with the mask clear.
// - Entry sets the mask and a latched request cannot be displaced.
// - Status bits read 1 while a source requests and 0 otherwise, read-only.
// -----------------------------------------------------------------
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ipv_top
    import ipv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sources
    input wire logic ext_pin_n,
    input wire logic lock_in,
    input wire logic [7:0] timer_event,
    input wire logic [7:0] periph_req,
    // Core handshake
    input wire logic insn_boundary,
    input wire logic trap_insn,
    input wire logic vector_taken,
    output logic irq_out,
    output logic [15:0] vector_addr,
    output logic mask_out
);
    import ipv_pkg::*;

    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    ipv_src_if src ();
    logic mask_reg, mask_next;
    logic [15:0] enable_reg, enable_next;
    logic [15:0] clr_pulse, set_pulse;
    logic soft_trap, soft_boundary, soft_ack;
    ipv_state_t state_reg, state_next;
    logic [4:0] prio_reg, prio_next;
    logic [15:0] vector_reg, vector_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic req_any;
    logic [4:0] win_prio;
    logic boundary, trap, taken, wb_req, wb_wr;

    // Vector of a priority: two bytes per step below the reset pair
    function automatic logic [15:0] vec_of(input logic [4:0] prio);
        // Priority 0 owns the trap pair; priority p sits p pairs below it
        vec_of = IPV_VEC_TRAP - 16'(prio) * IPV_VEC_STEP;
    endfunction

    // Byte-lane merge used by the enable, flag clear and source set writes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
        input logic [15:0] wdat, input logic [1:0] sel);
        lane_merge = old;
        if (sel[0]) begin
            lane_merge[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = wdat[15:8];
        end
    endfunction

    // -------------------------------------------------------------
    // Source collection and arbitration
    // -------------------------------------------------------------
    ipv_collect u_collect (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .ext_pin_n(ext_pin_n),
        .lock_in(lock_in),
        .event_in(timer_event),
        .other_req(periph_req),
        .clr(clr_pulse),
        .set(set_pulse),
        .src(src.collect)
    );

    ipv_arbiter u_arbiter (
        .src(src.arbiter),
        .req_any(req_any),
        .win_prio(win_prio)
    );

    assign src.enables = enable_reg;

    // -------------------------------------------------------------
    // Wishbone slave
    // -------------------------------------------------------------
    // Single-wait answer; ack drops the cycle after it rose
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    // Writes land at the edge where the master sees ack, not one edge earlier
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

    always_comb begin
        ack_next = wb_req;
        rdata_next = rdata_reg;
        enable_next = enable_reg;
        clr_pulse = 16'h0000;
        set_pulse = 16'h0000;
        soft_trap = 1'b0;
        soft_boundary = 1'b0;
        soft_ack = 1'b0;
        if (wb_wr && wb_adr_i == IPV_ADDR_ENABLE) begin
            enable_next = lane_merge(enable_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (wb_wr && wb_adr_i == IPV_ADDR_FLAG_CLR) begin
            clr_pulse = lane_merge(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (wb_wr && wb_adr_i == IPV_ADDR_SRC_SET) begin
            set_pulse = lane_merge(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (wb_wr && wb_adr_i == IPV_ADDR_CTRL && wb_sel_i[0]) begin
            soft_trap = wb_dat_i[IPV_CTRL_TRAP_BIT];
            soft_boundary = wb_dat_i[IPV_CTRL_BOUNDARY_BIT];
            soft_ack = wb_dat_i[IPV_CTRL_ACK_BIT];
        end
        // Read data; unmapped addresses read zero and still ack
        if (wb_req) begin
            if (wb_adr_i == IPV_ADDR_CTRL) begin
                rdata_next = 32'(mask_reg);
            end else if (wb_adr_i == IPV_ADDR_ENABLE) begin
                rdata_next = 32'(enable_reg);
            end else if (wb_adr_i == IPV_ADDR_FLAGS) begin
                rdata_next = 32'(src.flags);
            end else if (wb_adr_i == IPV_ADDR_STATUS) begin
                rdata_next = 32'(src.gated);
            end else if (wb_adr_i == IPV_ADDR_VECTOR) begin
                rdata_next = {11'h000, prio_reg, vector_reg};
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    // -------------------------------------------------------------
    // Core handshake and vectoring
    // -------------------------------------------------------------
    assign boundary = insn_boundary | soft_boundary;
    assign trap = trap_insn | soft_trap;
    assign taken = vector_taken | soft_ack;

    // Once latched, the chosen vector is frozen until the core takes it
    always_comb begin
        state_next = state_reg;
        prio_next = prio_reg;
        vector_next = vector_reg;
        mask_next = mask_reg;
        if (wb_wr && wb_adr_i == IPV_ADDR_CTRL && wb_sel_i[0]) begin
            mask_next = wb_dat_i[IPV_CTRL_MASK_BIT];
        end
        case (state_reg)
            IPV_IDLE: begin
                if (boundary && trap) begin
                    // The trap ignores the mask entirely
                    state_next = IPV_LATCHED;
                    prio_next = IPV_PRIO_TRAP;
                    vector_next = IPV_VEC_TRAP;
                    mask_next = 1'b1;
                end else if (boundary && !mask_reg && req_any) begin
                    state_next = IPV_LATCHED;
                    prio_next = win_prio;
                    vector_next = vec_of(win_prio);
                    mask_next = 1'b1;
                end
            end
            IPV_LATCHED: begin
                // No re-arbitration here: a higher source waits its turn
                if (taken) begin
                    state_next = IPV_IDLE;
                end
            end
            default: begin
                state_next = IPV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= IPV_IDLE;
            prio_reg <= IPV_PRIO_NONE;
            vector_reg <= IPV_VEC_RESET;
            mask_reg <= IPV_MASK_RST;
            enable_reg <= 16'h0000;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            state_reg <= state_next;
            prio_reg <= prio_next;
            vector_reg <= vector_next;
            mask_reg <= mask_next;
            enable_reg <= enable_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign irq_out = (state_reg == IPV_LATCHED);
    assign vector_addr = vector_reg;
    assign mask_out = mask_reg;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    mask_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && state_reg == IPV_IDLE && mask_reg && !trap |=> state_reg == IPV_IDLE)
        else $error("masked request was latched");
    trap_taken_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && state_reg == IPV_IDLE && boundary && trap
        |=> irq_out && vector_addr == 16'hfffc)
        else $error("trap not taken");
    prio_win_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && state_reg == IPV_IDLE && boundary && !trap && !mask_reg
        && src.gated[0] |=> prio_reg == 5'h01 && vector_addr == 16'hfffa)
        else $error("external pin did not win");
    vec_map_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_out && prio_reg != IPV_PRIO_TRAP |-> vector_addr == vec_of(prio_reg))
        else $error("vector does not match priority");
    boundary_only_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && state_reg == IPV_IDLE && !boundary |=> state_reg == IPV_IDLE)
        else $error("request latched off a boundary");
    entry_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(irq_out) |-> mask_reg)
        else $error("entry left mask clear");
    latched_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_out && !taken |=> irq_out && $stable(vector_addr))
        else $error("latched vector displaced");
    enable_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        !enable_reg[IPV_SRC_LOCK] |-> !src.gated[IPV_SRC_LOCK]
        && (src.gated & ~enable_reg) == 16'h0000)
        else $error("disabled source requests");
endmodule
`default_nettype wire

// *** sim/ipv_core_model.sv ***
// Behavioural processor core: instruction boundaries, software trap and vector fetch
`timescale 1ns/10ps
`default_nettype none
module ipv_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench controls
    input wire logic run,
    input wire logic trap_req,
    input wire logic slow,
    // Block side
    input wire logic irq_out,
    input wire logic [15:0] vector_addr,
    output logic insn_boundary,
    output logic trap_insn,
    output logic vector_taken,
    output logic [15:0] taken_vec
);
    logic [1:0] phase_reg;
    logic [3:0] wait_reg;

    // Boundaries keep coming while a request is latched, to stress the latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 2'h0;
            wait_reg <= 4'h0;
            insn_boundary <= 1'b0;
            trap_insn <= 1'b0;
            vector_taken <= 1'b0;
            taken_vec <= 16'h0000;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            insn_boundary <= run && phase_reg == 2'h3;
            trap_insn <= run && trap_req && phase_reg == 2'h3;
            vector_taken <= 1'b0;
            // Slow fetch leaves room for a late, higher request to arrive
            if (vector_taken || !irq_out) begin
                wait_reg <= 4'h0;
            end else if (wait_reg == (slow ? 4'hf : 4'h1)) begin
                vector_taken <= 1'b1;
                taken_vec <= vector_addr;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/interrupt_priority_vectoring_test.sv ***
// Self-checking testbench of the interrupt priority and vector block
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_vectoring_test
    import ipv_pkg::*;
;
    logic clk, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, timer_event, periph_req;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic ext_pin_n, lock_in, insn_boundary, trap_insn, vector_taken;
    logic irq_out, mask_out, run, trap_req, slow;
    logic [15:0] vector_addr, taken_vec;
    int err_total = 0;
    int total_checks = 0;
    logic [31:0] clr_tab [3] = '{32'h8, 32'h4, 32'h80};
    logic [15:0] vec_tab [3] = '{16'hfff6, 16'hffec, 16'hffdc};

    ipv_top i_ipv_top (.clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_pin_n(ext_pin_n), .lock_in(lock_in), .timer_event(timer_event),
        .periph_req(periph_req), .insn_boundary(insn_boundary), .trap_insn(trap_insn),
        .vector_taken(vector_taken), .irq_out(irq_out), .vector_addr(vector_addr),
        .mask_out(mask_out));

    ipv_core_model i_ipv_core_model (.clk(clk), .nrst(nrst), .run(run),
        .trap_req(trap_req), .slow(slow), .irq_out(irq_out), .vector_addr(vector_addr),
        .insn_boundary(insn_boundary), .trap_insn(trap_insn),
        .vector_taken(vector_taken), .taken_vec(taken_vec));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Reporting and comparisons
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic give_up(input string n);
        $display("unexpected %s expected answer seen none", n);
        err_total++;
        finish_test();
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    // ------------------------------------------------------------
    // Classic Wishbone single cycle; waits for ack under a bound
    // ------------------------------------------------------------
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 40) give_up("wb_ack_o");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        chk_word(n, e, q);
    endtask

    // Event on source i: pin falls and rises, lock toggles, timers pulse
    task automatic raise(input int i);
        @(posedge clk);
        if (i == 0) ext_pin_n <= 1'b0;
        else if (i == 1) lock_in <= !lock_in;
        else timer_event <= 8'h01 << i;
        @(posedge clk);
        timer_event <= 8'h00;
        repeat (6) @(posedge clk);
        ext_pin_n <= 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_out !== lvl && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) give_up("irq_out");
    endtask

    // One service: latched vector, mask set on entry, fetched vector
    task automatic serve(input logic [15:0] e);
        wait_irq(1'b1);
        chk_vec("vector_addr", e, vector_addr);
        chk_bit("mask_out", 1'b1, mask_out);
        wait_irq(1'b0);
        chk_vec("taken_vec", e, taken_vec);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, run, trap_req, slow} = 7'h00;
        {ce, ext_pin_n, lock_in} = 3'b110;
        {wb_adr_i, timer_event, periph_req} = 24'h000000;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk_bit("irq_out", 1'b0, irq_out);
        chk_vec("vector_addr", 16'hfffe, vector_addr);
        rd(IPV_ADDR_CTRL, 32'h1, "ctrl");
        rd(8'h40, 32'h0, "unmapped");
        wr(IPV_ADDR_STATUS, 32'hffff);
        rd(IPV_ADDR_STATUS, 32'h0, "status");
        run <= 1'b1;
        // Every local source: flag, its enable, entry and vector
        for (int i = 0; i < 8; i++) begin
            raise(i);
            rd(IPV_ADDR_FLAGS, 32'h1 << i, "flags");
            rd(IPV_ADDR_STATUS, 32'h0, "status");
            wr(IPV_ADDR_ENABLE, 32'h1 << i);
            rd(IPV_ADDR_STATUS, 32'h1 << i, "status");
            wr(IPV_ADDR_CTRL, 32'h0);
            serve(16'hfffc - 16'(2 * (i + 1)));
            wr(IPV_ADDR_FLAG_CLR, 32'h1 << i);
            wr(IPV_ADDR_ENABLE, 32'h0);
        end
        // Several pending while masked, then with no boundaries
        wr(IPV_ADDR_ENABLE, 32'hffff);
        periph_req <= 8'h80;
        raise(7);
        raise(3);
        repeat (20) @(negedge clk);
        chk_bit("irq_out", 1'b0, irq_out);
        @(posedge clk);
        run <= 1'b0;
        wr(IPV_ADDR_CTRL, 32'h0);
        repeat (20) @(negedge clk);
        chk_bit("irq_out", 1'b0, irq_out);
        @(posedge clk);
        slow <= 1'b1;
        run <= 1'b1;
        // A higher request arriving after the latch must wait its turn
        wait_irq(1'b1);
        raise(2);
        serve(16'hfff4);
        for (int k = 0; k < 3; k++) begin
            wr(IPV_ADDR_FLAG_CLR, clr_tab[k]);
            wr(IPV_ADDR_CTRL, 32'h0);
            serve(vec_tab[k]);
        end
        // Trap is taken with the mask set and a request pending
        @(posedge clk);
        trap_req <= 1'b1;
        wait_irq(1'b1);
        @(posedge clk);
        trap_req <= 1'b0;
        periph_req <= 8'h00;
        serve(16'hfffc);
        // Leaving lock sets the flag as well as entering it
        raise(1);
        rd(IPV_ADDR_FLAGS, 32'h2, "flags");
        finish_test();
    end
endmodule
`default_nettype wire
